//--- hdl/dac_link_pkg.sv
// constants and types shared by the serial load front end
package dac_link_pkg;

	// frame geometry
	localparam int unsigned WORD_BITS_DEF = 32;
	localparam int unsigned BIT_CNT_W     = 6;
	localparam logic [5:0]  BIT_CNT_RST   = 6'h00;

	// pin synchroniser layout
	localparam int unsigned PIN_COUNT     = 5;
	localparam int unsigned PIN_FRAME     = 0;
	localparam int unsigned PIN_SCLK      = 1;
	localparam int unsigned PIN_DIN       = 2;
	localparam int unsigned PIN_LOAD      = 3;
	localparam int unsigned PIN_CLEAR     = 4;
	localparam logic [4:0]  PIN_RST       = 5'h1B;

	// two-entry buffer
	localparam int unsigned BUF_DEPTH     = 2;
	localparam logic [1:0]  BUF_CNT_RST   = 2'h0;

	// clear-code setting values
	typedef enum logic [1:0] {
		CLEAR_ZERO = 2'h0,
		CLEAR_MID  = 2'h1,
		CLEAR_FULL = 2'h2
	} clear_code_type;
	localparam clear_code_type CLEAR_CODE_RST = CLEAR_ZERO;

	// reference selection
	localparam logic REF_EXTERNAL = 1'b0;
	localparam logic REF_INTERNAL = 1'b1;
	localparam logic REF_SEL_RST  = REF_EXTERNAL;

	// frame state machine, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_HOLD  = 3'h4
	} frame_state_type;
	localparam frame_state_type FRAME_ST_RST = ST_IDLE;

endpackage

//--- hdl/word_buffer.sv
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buffer
	import dac_link_pkg::*;
#(
	parameter int unsigned WIDTH = WORD_BITS_DEF
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);

	// a zero-width buffer cannot carry a word
	if (WIDTH < 1) begin : g_bad_width
		$error("word_buffer width must be at least one");
	end

	logic [WIDTH-1:0] head_q;
	logic [WIDTH-1:0] tail_q;
	logic [1:0]       count_q;
	logic [1:0]       count_d;
	logic             push;
	logic             pop;

	// handshake decode
	assign push        = in_valid_i & (count_q != 2'(BUF_DEPTH));
	assign pop         = out_valid_o & out_ready_i;
	assign in_ready_o  = count_q != 2'(BUF_DEPTH);
	assign out_data_o  = head_q;
	assign count_d     = 2'(count_q + {1'b0, push} - {1'b0, pop});

	// occupancy and flopped valid
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q     <= BUF_CNT_RST;
			out_valid_o <= 1'b0;
		end else begin
			count_q     <= count_d;
			out_valid_o <= count_d != BUF_CNT_RST;
		end
	end

	// head always holds the oldest word
	always_ff @(posedge clock_i) begin
		if (push && (count_q == 2'h0 || (count_q == 2'h1 && pop))) begin
			head_q <= in_data_i;
		end else if (pop) begin
			head_q <= tail_q;
		end
		if (push && (count_q == 2'h2 || (count_q == 2'h1 && !pop))) begin
			tail_q <= in_data_i;
		end
	end

endmodule

//--- hdl/dac_serial_load.sv
// serial frame capture, load strobe and clear control of the octal dac front end
`timescale 1ns/1ps
module dac_serial_load
	import dac_link_pkg::*;
#(
	parameter int unsigned WORD_BITS = WORD_BITS_DEF
) (
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 frame_sel_n_i,
	input  wire logic                 sclk_i,
	input  wire logic                 din_i,
	input  wire logic                 load_strobe_n_i,
	input  wire logic                 async_clear_n_i,
	input  wire logic                 clear_code_wr_i,
	input  wire logic [1:0]           clear_code_i,
	input  wire logic                 ref_sel_wr_i,
	input  wire logic                 ref_sel_i,
	output logic      [WORD_BITS-1:0] word_o,
	output logic                      word_valid_o,
	input  wire logic                 word_ready_i,
	output logic                      frame_active_o,
	output logic                      load_xfer_o,
	output logic                      clear_xfer_o,
	output logic      [1:0]           clear_code_o,
	output logic                      ref_pin_oe_o
);

	// only the documented frame length is served, and the bit counter must reach it
	if (WORD_BITS != WORD_BITS_DEF) begin : g_bad_length
		$error("frame length must be 32 bits");
	end
	if (WORD_BITS >= (1 << BIT_CNT_W)) begin : g_bad_count
		$error("bit counter too narrow for the frame");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] s1_q;
	logic [PIN_COUNT-1:0] s2_q;
	logic [PIN_COUNT-1:0] s3_q;
	logic [PIN_COUNT-1:0] filt_q;
	logic [PIN_COUNT-1:0] filt_d;
	logic [PIN_COUNT-1:0] fall;
	logic [PIN_COUNT-1:0] rise;

	assign pins = {async_clear_n_i, load_strobe_n_i, din_i, sclk_i, frame_sel_n_i};

	// three synchroniser flops and a filter flop per pin, change taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			assign filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
			assign fall[gi]   = filt_q[gi] & ~filt_d[gi];
			assign rise[gi]   = ~filt_q[gi] & filt_d[gi];
			// stages reset to the pin's idle level, so release makes no false edge
			always_ff @(posedge clock_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					s1_q[gi]   <= PIN_RST[gi];
					s2_q[gi]   <= PIN_RST[gi];
					s3_q[gi]   <= PIN_RST[gi];
					filt_q[gi] <= PIN_RST[gi];
				end else begin
					s1_q[gi]   <= pins[gi];
					s2_q[gi]   <= s1_q[gi];
					s3_q[gi]   <= s2_q[gi];
					filt_q[gi] <= filt_d[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// frame capture

	frame_state_type      state_q;
	frame_state_type      state_d;
	logic [WORD_BITS-1:0] shift_q;
	logic [BIT_CNT_W-1:0] bit_cnt_q;
	logic                 buf_ready;
	logic                 push_word;
	logic                 bit_take;
	logic                 last_bit;
	logic                 frame_open;
	logic                 frame_abort;

	// frame events: open, abort, taken bit, last bit and hand-over
	// a select fall met in HOLD is dropped, so the decoder must keep draining
	assign frame_open  = fall[PIN_FRAME];
	assign frame_abort = rise[PIN_FRAME];
	assign bit_take    = (state_q == ST_SHIFT) & fall[PIN_SCLK]
		& ~frame_abort;
	assign last_bit    = bit_take & (bit_cnt_q == BIT_CNT_W'(WORD_BITS - 1));
	assign push_word   = (state_q == ST_HOLD) & buf_ready;

	// next state of the frame sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (frame_open) begin
					state_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (frame_abort) begin
					state_d = ST_IDLE;
				end else if (last_bit) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (buf_ready) begin
					state_d = ST_IDLE;
				end
			end
			// a corrupted one-hot code falls back to waiting for a frame
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// sequencer state and bit count
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q        <= FRAME_ST_RST;
			bit_cnt_q      <= BIT_CNT_RST;
			frame_active_o <= 1'b0;
		end else begin
			state_q        <= state_d;
			frame_active_o <= state_d == ST_SHIFT;
			if (state_q == ST_IDLE) begin
				bit_cnt_q <= BIT_CNT_RST;
			end else if (bit_take) begin
				bit_cnt_q <= BIT_CNT_W'(bit_cnt_q + 1'b1);
			end
		end
	end

	// msb-first shift register, only moves on a taken bit
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= '0;
		end else if (bit_take) begin
			shift_q <= {shift_q[WORD_BITS-2:0], filt_q[PIN_DIN]};
		end
	end

	// completed words wait here for the command decoder
	word_buffer #(
		.WIDTH       (WORD_BITS)
	) u_buffer (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (shift_q),
		.in_valid_i  (push_word),
		.in_ready_o  (buf_ready),
		.out_data_o  (word_o),
		.out_valid_o (word_valid_o),
		.out_ready_i (word_ready_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	// load strobe, clear and settings

	logic clear_low;
	logic load_evt;
	logic word_taken;

	// the clear's own falling cycle blocks a load as well
	// a strobe held low turns each word taken by the decoder into a transfer
	assign clear_low  = ~filt_q[PIN_CLEAR] | fall[PIN_CLEAR];
	assign word_taken = word_valid_o & word_ready_i;
	assign load_evt   = fall[PIN_LOAD]
		| (~filt_q[PIN_LOAD] & word_taken);

	// one-cycle transfer pulses
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			load_xfer_o  <= 1'b0;
			clear_xfer_o <= 1'b0;
		end else begin
			load_xfer_o  <= load_evt & ~clear_low;
			clear_xfer_o <= fall[PIN_CLEAR];
		end
	end

	// clear code and reference selection
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_code_o <= CLEAR_CODE_RST;
			ref_pin_oe_o <= REF_SEL_RST;
		end else begin
			// writes come as one-cycle pulses from the command decoder
			if (clear_code_wr_i) begin
				clear_code_o <= clear_code_i;
			end
			if (ref_sel_wr_i) begin
				ref_pin_oe_o <= ref_sel_i;
			end
		end
	end

endmodule

//--- sim/dac_serial_load_chk.sv
// assertion checker for the serial load front end
`timescale 1ns/1ps
module dac_serial_load_chk
	import dac_link_pkg::*;
#(
	parameter int unsigned WORD_BITS = WORD_BITS_DEF
) (
	input wire logic                 clock_i,
	input wire logic                 rst_n_i,
	input wire logic                 frame_sel_n_i,
	input wire logic                 load_strobe_n_i,
	input wire logic                 async_clear_n_i,
	input wire logic                 clear_code_wr_i,
	input wire logic [1:0]           clear_code_i,
	input wire logic                 ref_sel_wr_i,
	input wire logic                 ref_sel_i,
	input wire logic [WORD_BITS-1:0] word_o,
	input wire logic                 word_valid_o,
	input wire logic                 word_ready_i,
	input wire logic                 frame_active_o,
	input wire logic                 load_xfer_o,
	input wire logic                 clear_xfer_o,
	input wire logic [1:0]           clear_code_o,
	input wire logic                 ref_pin_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	clear_blocks_load_a: assert property (!async_clear_n_i [*6] |-> !load_xfer_o)
		else $error("load transfer while clear held low");
	load_moves_a: assert property ($fell(load_strobe_n_i) && async_clear_n_i
		|-> ##[2:7] load_xfer_o)
		else $error("no load transfer after strobe");
	clear_acts_a: assert property ($fell(async_clear_n_i) |-> ##[1:8] clear_xfer_o)
		else $error("no clear transfer after clear fall");
	clear_pulse_a: assert property (clear_xfer_o |=> !clear_xfer_o)
		else $error("clear transfer longer than one cycle");
	frame_closed_a: assert property (frame_sel_n_i [*6] |-> !frame_active_o)
		else $error("frame active with select high");
	word_stands_a: assert property (word_valid_o && !word_ready_i
		|=> word_valid_o && $stable(word_o))
		else $error("word dropped before pop");
	clear_code_set_a: assert property (clear_code_wr_i
		|=> clear_code_o == $past(clear_code_i))
		else $error("clear code not taken");
	frame_opens_a: assert property ($rose(frame_active_o) |-> !$past(frame_sel_n_i, 4))
		else $error("frame active without a select fall");
	frame_abort_a: assert property ($rose(frame_sel_n_i) && frame_active_o
		|-> ##4 !frame_active_o)
		else $error("frame still active after select rise");
	ref_select_a: assert property (ref_sel_wr_i |=> ref_pin_oe_o == $past(ref_sel_i))
		else $error("reference select not taken");
endmodule
bind dac_serial_load dac_serial_load_chk #(.WORD_BITS(WORD_BITS)) chk_u (.*);

//--- sim/serial_host.sv
// host side serial link model
`timescale 1ns/1ps
module serial_host (
	input  wire logic        go_i,
	input  wire logic [31:0] word_i,
	input  wire logic [5:0]  nbits_i,
	output logic             frame_sel_n_o,
	output logic             sclk_o,
	output logic             din_o,
	output logic             busy_o
);
	int i;
	initial begin
		frame_sel_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
		busy_o = 1'b0;
	end
	// one frame per go, msb first, link clock still outside frames
	always @(posedge go_i) begin
		busy_o = 1'b1;
		#5.3 frame_sel_n_o = 1'b0;
		for (i = 0; i < nbits_i; i++) begin
			din_o = word_i[31-i];
			#24 sclk_o = 1'b0;
			#24 sclk_o = 1'b1;
		end
		#24 frame_sel_n_o = 1'b1;
		din_o = ~din_o; // released line shows no stale bit
		#24 busy_o = 1'b0;
	end
endmodule

//--- sim/test_dac_serial_load.sv
// self-checking bench for the serial load front end
`timescale 1ns/1ps
module test_dac_serial_load;
	import dac_link_pkg::*;
	logic        clock_i, rst_n_i, load_n, clr_n, cc_wr, ref_wr, ref_sel, ready, go;
	logic [1:0]  cc;
	logic [31:0] wd, w0, w1;
	logic [5:0]  nb, na;
	wire         frame_n, sclk, din, busy, valid, active, ldx, clx, oe;
	wire  [31:0] word;
	wire  [1:0]  cco;
	int          fail_count, num_checks, seed, loads, clears, t, k, l0, c0, acts, a0;
	serial_host host_u (.go_i(go), .word_i(wd), .nbits_i(nb), .frame_sel_n_o(frame_n),
		.sclk_o(sclk), .din_o(din), .busy_o(busy));
	dac_serial_load dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .frame_sel_n_i(frame_n),
		.sclk_i(sclk), .din_i(din), .load_strobe_n_i(load_n), .async_clear_n_i(clr_n),
		.clear_code_wr_i(cc_wr), .clear_code_i(cc), .ref_sel_wr_i(ref_wr), .ref_sel_i(ref_sel),
		.word_o(word), .word_valid_o(valid), .word_ready_i(ready), .frame_active_o(active),
		.load_xfer_o(ldx), .clear_xfer_o(clx), .clear_code_o(cco), .ref_pin_oe_o(oe));
	always #2 clock_i = ~clock_i;
	// load and clear pulse counters, frame active cycle counter
	always @(posedge clock_i) begin
		if (ldx === 1'b1) loads++;
		if (clx === 1'b1) clears++;
		if (active === 1'b1) acts++;
	end
	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task await(input logic lvl, input int lim);
		for (t = 0; (lvl ? valid : busy) !== lvl; t++) begin
			if (t > lim) begin
				fail_count++;
				results;
			end
			cyc(1);
		end
	endtask
	task frame(input logic [31:0] w, input logic [5:0] n);
		wd = w;
		nb = n;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		await(1'b0, 800);
	endtask
	task pop;
		ready = 1'b1;
		cyc(1);
		ready = 1'b0;
		cyc(1);
	endtask
	task strobe(input int n);
		l0 = loads;
		load_n = 1'b0;
		cyc(6);
		load_n = 1'b1;
		cyc(8);
		check("load pulses", n, loads - l0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{clock_i, rst_n_i, cc_wr, ref_wr, ref_sel, ready, go, cc, wd, nb} = '0;
		{load_n, clr_n} = 2'h3;
		seed = 32'hd234b082;
		cyc(5);
		rst_n_i = 1'b1;
		cyc(5);
		check("clear code", CLEAR_ZERO, cco);
		check("ref oe", 1'b0, oe);
		// two frames into a stalled buffer, then drained in order
		for (k = 0; k < 4; k++) begin
			w0 = k ? $random(seed) : 32'h80000001;
			w1 = k ? $random(seed) : 32'h7FFFFFFE;
			a0 = acts;
			frame(w0, 6'h20);
			check("frame active", 1'b1, acts > a0);
			frame(w1, 6'h20);
			await(1'b1, 20);
			check("first word", w0, word);
			pop;
			await(1'b1, 20);
			check("second word", w1, word);
			pop;
			cyc(3);
			check("drained", 1'b0, valid);
		end
		$display("frames done");
		// aborted frames leave nothing
		for (k = 0; k < 3; k++) begin
			na = k == 0 ? 6'h01 : 6'h1F;
			if (k == 2) begin
				na = 6'($unsigned($random(seed)) % 30 + 1);
			end
			frame($random(seed), na);
			cyc(8);
			check("abort", 1'b0, valid);
			w0 = $random(seed);
			frame(w0, 6'h20);
			await(1'b1, 20);
			check("word after abort", w0, word);
			pop;
		end
		$display("aborts done");
		strobe(1);
		c0 = clears;
		clr_n = 1'b0;
		cyc(8);
		strobe(0);
		check("clear pulses", 1, clears - c0);
		clr_n = 1'b1;
		cyc(8);
		$display("clear done");
		for (k = 0; k < 4; k++) begin
			cc = 2'(k);
			ref_sel = ~k[0];
			{cc_wr, ref_wr} = 2'h3;
			cyc(1);
			{cc_wr, ref_wr} = 2'h0;
			cyc(1);
			check("code set", k, cco);
			check("ref set", {31'h0, ~k[0]}, oe);
		end
		$display("settings done");
		load_n = 1'b0;
		cyc(8);
		l0 = loads;
		w0 = $random(seed);
		frame(w0, 6'h20);
		await(1'b1, 20);
		check("held frame word", w0, word);
		pop;
		cyc(5);
		check("held strobe", 1, loads - l0);
		load_n = 1'b1;
		$display("held strobe done");
		results;
	end
endmodule
